// file: design/threshold_code_ctrl.sv
// Supply voltage detector controller with AHB-Lite register slave
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module threshold_code_ctrl #(
  parameter int unsigned INT_DIV = threshold_code_pkg::INTERNAL_DIV,
  parameter int unsigned HS_DIV  = threshold_code_pkg::HIGH_SPEED_DIV
) (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        internalOsc,
  input  wire logic        lowSpeedOsc,
  input  wire logic        highSpeedOsc,
  input  wire logic        compLow,
  output logic             monitorClk,
  output logic             monitorEnable,
  output logic [3:0]       thresholdCode,
  output logic             dropIrq
);
  import threshold_code_pkg::*;

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    threshold_code_phase_type phase;
    logic [31:0]    addr;
    logic [1:0]     clockSourceSel;
    logic           clockGateEn;
    logic           monitorEnable;
    logic [3:0]     thresholdCode;
    logic           dropIrqEnable;
    logic           dropFlag;
    logic           lowSupplyResult;
    logic [1:0]     compSync;
    logic [31:0]    rdata;
    logic           irq;
  } threshold_code_ctrl_state_type;

  localparam threshold_code_ctrl_state_type RESET_STATE = '{
    phase:           PH_IDLE,
    addr:            32'h00000000,
    clockSourceSel:  CLOCK_SOURCE_SEL_RESET,
    clockGateEn:     CLOCK_GATE_EN_RESET,
    monitorEnable:   MONEN_RESET,
    thresholdCode:   THR_RESET,
    dropIrqEnable:   IRQEN_RESET,
    dropFlag:        FLAG_RESET,
    lowSupplyResult: RESULT_RESET,
    compSync:        2'h0,
    rdata:           32'h00000000,
    irq:             1'b0
  };

  threshold_code_ctrl_state_type state_reg;
  threshold_code_ctrl_state_type state_next;
  logic                monitorTick;
  logic                addrTake;
  logic                wrFire;
  logic                flagClear;
  logic                detectLow;

  // ==========================================================================
  // Detector clock generation
  // ==========================================================================
  threshold_code_clock_gen #(
    .INT_DIV (INT_DIV),
    .HS_DIV  (HS_DIV)
  ) u_clock_gen (
    .mclk           (mclk),
    .reset          (reset),
    .internalOsc    (internalOsc),
    .lowSpeedOsc    (lowSpeedOsc),
    .highSpeedOsc   (highSpeedOsc),
    .clockSourceSel (state_reg.clockSourceSel),
    .clockGateEn    (state_reg.clockGateEn),
    .monitorTick    (monitorTick),
    .monitorClk     (monitorClk)
  );

  // ==========================================================================
  // Register read multiplexer, reserved bits zero
  // ==========================================================================
  function automatic logic [31:0] read_value(input logic [31:0] a,
                                             input threshold_code_ctrl_state_type s);
    logic [REG_WIDTH-1:0] v;
    v = '0;
    if (a == threshold_code_byte_addr(IDX_CLOCK_CTRL)) begin
      v[CLOCK_SOURCE_SEL_MSB:CLOCK_SOURCE_SEL_LSB] = s.clockSourceSel;
      v[CLOCK_GATE_EN_BIT] = s.clockGateEn;
    end else if (a == threshold_code_byte_addr(IDX_ENABLE)) begin
      v[MONEN_BIT] = s.monitorEnable;
    end else if (a == threshold_code_byte_addr(IDX_THRESHOLD)) begin
      v[THR_MSB:THR_LSB] = s.thresholdCode;
    end else if (a == threshold_code_byte_addr(IDX_RESULT)) begin
      v[RESULT_BIT] = s.lowSupplyResult;
    end else if (a == threshold_code_byte_addr(IDX_IRQ_MASK)) begin
      v[IRQEN_BIT] = s.dropIrqEnable;
    end else if (a == threshold_code_byte_addr(IDX_DROP_FLAG)) begin
      v[FLAG_BIT] = s.dropFlag;
    end
    return {24'h000000, v};
  endfunction

  // Address phase accepted whenever selected and ready with a transfer pending
  assign addrTake = hsel && hready && htrans[1];
  assign wrFire = (state_reg.phase == PH_WRITE);
  assign flagClear = wrFire && (state_reg.addr == threshold_code_byte_addr(IDX_DROP_FLAG)) && hwdata[FLAG_BIT];
  // Ticks stop one cycle after the gate closes, so no detection happens then
  assign detectLow = monitorTick && state_reg.monitorEnable && state_reg.compSync[1];

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    state_next = state_reg;
    // Bus phase tracking; non-word writes are dropped
    if (addrTake && hwrite && (hsize == HSIZE_WORD)) begin
      state_next.phase = PH_WRITE;
    end else if (addrTake && !hwrite) begin
      state_next.phase = PH_READ;
    end else begin
      state_next.phase = PH_IDLE;
    end
    if (addrTake) begin
      state_next.addr = haddr;
    end
    // Data phase write, reserved bits discarded
    if (wrFire) begin
      if (state_reg.addr == threshold_code_byte_addr(IDX_CLOCK_CTRL)) begin
        state_next.clockSourceSel = hwdata[CLOCK_SOURCE_SEL_MSB:CLOCK_SOURCE_SEL_LSB];
        state_next.clockGateEn = hwdata[CLOCK_GATE_EN_BIT];
      end else if (state_reg.addr == threshold_code_byte_addr(IDX_ENABLE)) begin
        state_next.monitorEnable = hwdata[MONEN_BIT];
      end else if (state_reg.addr == threshold_code_byte_addr(IDX_THRESHOLD)) begin
        state_next.thresholdCode = hwdata[THR_MSB:THR_LSB];
      end else if (state_reg.addr == threshold_code_byte_addr(IDX_IRQ_MASK)) begin
        state_next.dropIrqEnable = hwdata[IRQEN_BIT];
      end
    end
    // Comparator: first stage only feeds the second
    state_next.compSync = {state_reg.compSync[0], compLow};
    if (monitorTick && state_reg.monitorEnable) begin
      state_next.lowSupplyResult = state_reg.compSync[1];
    end
    // Clear first so that a detection in the same cycle wins
    if (flagClear) begin
      state_next.dropFlag = 1'b0;
    end
    if (detectLow) begin
      state_next.dropFlag = 1'b1;
    end
    state_next.irq = state_next.dropFlag && state_next.dropIrqEnable;
    // Read data sampled from next state, so a write just before is seen
    if (addrTake && !hwrite) begin
      state_next.rdata = read_value(haddr, state_next);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_reg <= RESET_STATE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // Outputs; zero wait states, always OKAY
  // ==========================================================================
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign hrdata = state_reg.rdata;
  assign monitorEnable = state_reg.monitorEnable;
  assign thresholdCode = state_reg.thresholdCode;
  assign dropIrq = state_reg.irq;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // Clock control comes out of reset with source one and gate off
  a_clk_reset: assert property ($past(reset) |-> state_reg.clockSourceSel == 2'h1 && !state_reg.clockGateEn)
    else $error("clock control reset value wrong");

  // Enable and threshold clear and interrupt request low after reset
  a_cfg_reset: assert property ($past(reset) |-> !monitorEnable && thresholdCode == 4'h0 && !dropIrq)
    else $error("configuration reset value wrong");

  // Gated clock means no ticks, so nothing is sampled
  a_gate_stops: assert property (!state_reg.clockGateEn |=> !monitorTick)
    else $error("detector tick while clock gated");

  // A tick launched just before the gate closed may still land, so it is excluded
  a_gate_nodetect: assert property (!state_reg.clockGateEn && !monitorTick && !state_reg.dropFlag && !flagClear
                                    ##1 !state_reg.clockGateEn |=> !state_reg.dropFlag)
    else $error("detection while clock gated");

  a_enable_write: assert property (wrFire && state_reg.addr == threshold_code_byte_addr(IDX_ENABLE)
                                   |=> monitorEnable == $past(hwdata[0]))
    else $error("enable write not applied");

  a_result_sample: assert property (monitorTick && state_reg.monitorEnable
                                    |=> state_reg.lowSupplyResult == $past(state_reg.compSync[1]))
    else $error("result not sampled on tick");

  a_flag_set: assert property (detectLow |=> state_reg.dropFlag)
    else $error("drop flag not set on low supply");

  a_flag_nodisable: assert property (!state_reg.monitorEnable && !state_reg.dropFlag |=> !state_reg.dropFlag)
    else $error("drop flag set while disabled");

  a_flag_sticky: assert property (state_reg.dropFlag && !flagClear |=> state_reg.dropFlag)
    else $error("drop flag lost without clear");

  a_flag_clear: assert property (flagClear && !detectLow |=> !state_reg.dropFlag)
    else $error("drop flag not cleared by write one");

  a_irq_follow: assert property (dropIrq == (state_reg.dropFlag && state_reg.dropIrqEnable))
    else $error("interrupt request mismatch");

  a_rdata_width: assert property (state_reg.phase == PH_READ |-> hrdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");

  a_flag_zero_wr: assert property (wrFire && state_reg.addr == threshold_code_byte_addr(IDX_DROP_FLAG)
                                   && !hwdata[0] && state_reg.dropFlag |=> state_reg.dropFlag)
    else $error("zero write changed drop flag");

  a_ready_okay: assert property (hreadyout && hresp == HRESP_OKAY)
    else $error("slave not ready or not okay");

  c_flag_set: cover property (detectLow);
  c_irq_raise: cover property (!dropIrq ##1 dropIrq);
  c_flag_cleared: cover property (state_reg.dropFlag ##1 flagClear ##1 !state_reg.dropFlag);
  c_result_read: cover property (state_reg.phase == PH_READ && hrdata[0]);

endmodule
`default_nettype wire

// file: design/threshold_code_pkg.sv
// Shared constants and types of the supply voltage detector controller
package threshold_code_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  // ==========================================================================
  localparam logic [15:0] IDX_CLOCK_CTRL = 16'h5066;
  localparam logic [15:0] IDX_ENABLE     = 16'h5100;
  localparam logic [15:0] IDX_THRESHOLD  = 16'h5101;
  localparam logic [15:0] IDX_RESULT     = 16'h5102;
  localparam logic [15:0] IDX_IRQ_MASK   = 16'h5103;
  localparam logic [15:0] IDX_DROP_FLAG  = 16'h5104;

  // Index to aligned word address
  function automatic logic [31:0] threshold_code_byte_addr(input logic [15:0] idx);
    return {14'h0, idx, 2'h0};
  endfunction

  // ==========================================================================
  // Field layout, all registers are eight bits wide
  // ==========================================================================
  localparam int unsigned REG_WIDTH  = 8;
  localparam int unsigned CLOCK_GATE_EN_BIT  = 0;
  localparam int unsigned CLOCK_SOURCE_SEL_LSB = 2;
  localparam int unsigned CLOCK_SOURCE_SEL_MSB = 3;
  localparam int unsigned MONEN_BIT  = 0;
  localparam int unsigned THR_LSB    = 0;
  localparam int unsigned THR_MSB    = 3;
  localparam int unsigned RESULT_BIT = 0;
  localparam int unsigned IRQEN_BIT  = 0;
  localparam int unsigned FLAG_BIT   = 0;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [1:0] CLOCK_SOURCE_SEL_RESET = 2'h1;
  localparam logic       CLOCK_GATE_EN_RESET  = 1'h0;
  localparam logic       MONEN_RESET  = 1'h0;
  localparam logic [3:0] THR_RESET    = 4'h0;
  localparam logic       IRQEN_RESET  = 1'h0;
  localparam logic       FLAG_RESET   = 1'h0;
  localparam logic       RESULT_RESET = 1'h0;

  // ==========================================================================
  // Clock source codes and dividers
  // ==========================================================================
  localparam logic [1:0] SRC_INTERNAL   = 2'h0;
  localparam logic [1:0] SRC_LOW_SPEED  = 2'h1;
  localparam logic [1:0] SRC_HIGH_SPEED = 2'h2;
  localparam logic [1:0] SRC_RESERVED   = 2'h3;
  localparam int unsigned INTERNAL_DIV   = 128;
  localparam int unsigned HIGH_SPEED_DIV = 512;

  // ==========================================================================
  // AHB-Lite encodings
  // ==========================================================================
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  // Bus slave phase, one-hot
  typedef enum logic [2:0] {
    PH_IDLE  = 3'h1,
    PH_WRITE = 3'h2,
    PH_READ  = 3'h4
  } threshold_code_phase_type;

endpackage

// file: design/threshold_code_clock_gen.sv
// Detector clock source selection, division and gating
`timescale 1ns/10ps
`default_nettype none
module threshold_code_clock_gen #(
  parameter int unsigned INT_DIV = threshold_code_pkg::INTERNAL_DIV,
  parameter int unsigned HS_DIV  = threshold_code_pkg::HIGH_SPEED_DIV
) (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       internalOsc,
  input  wire logic       lowSpeedOsc,
  input  wire logic       highSpeedOsc,
  input  wire logic [1:0] clockSourceSel,
  input  wire logic       clockGateEn,
  output logic            monitorTick,
  output logic            monitorClk
);
  import threshold_code_pkg::*;

  localparam int unsigned IW = $clog2(INT_DIV);
  localparam int unsigned HW = $clog2(HS_DIV);
  localparam logic [IW-1:0] INT_PRE = IW'(INT_DIV / 2 - 1);
  localparam logic [HW-1:0] HS_PRE  = HW'(HS_DIV / 2 - 1);

  // ==========================================================================
  // Parameter check: dividers must be powers of two, at least two
  // ==========================================================================
  if (INT_DIV < 2 || (INT_DIV & (INT_DIV - 1)) != 0) begin : g_bad_int
    $error("internal divider must be a power of two");
  end
  if (HS_DIV < 2 || (HS_DIV & (HS_DIV - 1)) != 0) begin : g_bad_hs
    $error("high speed divider must be a power of two");
  end

  typedef struct packed {
    logic [2:0]    sync1;
    logic [2:0]    sync2;
    logic [2:0]    prev;
    logic [IW-1:0] intCnt;
    logic [HW-1:0] hsCnt;
    logic          tick;
    logic          clkOut;
  } threshold_code_gen_state_type;

  threshold_code_gen_state_type state_reg;
  threshold_code_gen_state_type state_next;
  logic [2:0]         oscRise;

  // ==========================================================================
  // Edge detect per oscillator, after the two-stage synchroniser
  // ==========================================================================
  for (genvar i = 0; i < 3; i++) begin : g_edge
    assign oscRise[i] = state_reg.sync2[i] & ~state_reg.prev[i];
  end

  // Oscillators must run below half of mclk to be sampled faithfully
  always_comb begin
    logic rise;
    logic lvl;
    rise = 1'b0;
    lvl = 1'b0;
    state_next = state_reg;
    state_next.sync1 = {highSpeedOsc, lowSpeedOsc, internalOsc};
    state_next.sync2 = state_reg.sync1;
    state_next.prev = state_reg.sync2;
    if (oscRise[0]) begin
      state_next.intCnt = IW'(state_reg.intCnt + 1'b1);
    end
    if (oscRise[2]) begin
      state_next.hsCnt = HW'(state_reg.hsCnt + 1'b1);
    end
    // Divided clock rises when its counter crosses the half count
    case (clockSourceSel)
      SRC_INTERNAL: begin
        rise = oscRise[0] && (state_reg.intCnt == INT_PRE);
        lvl = state_next.intCnt[IW-1];
      end
      SRC_LOW_SPEED: begin
        rise = oscRise[1];
        lvl = state_reg.sync2[1];
      end
      SRC_HIGH_SPEED: begin
        rise = oscRise[2] && (state_reg.hsCnt == HS_PRE);
        lvl = state_next.hsCnt[HW-1];
      end
      default: begin
        rise = 1'b0;
        lvl = 1'b0;
      end
    endcase
    state_next.tick = clockGateEn & rise;
    state_next.clkOut = clockGateEn & lvl;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign monitorTick = state_reg.tick;
  assign monitorClk = state_reg.clkOut;

endmodule
`default_nettype wire

// file: dv/threshold_code_analog_model.sv
// Behavioural model of the analogue side: three oscillators and the supply comparator
`timescale 1ns/10ps
`default_nettype none
module threshold_code_analog_model #(
  parameter int INT_HALF_NS = 60,
  parameter int LOW_HALF_NS = 80,
  parameter int HS_HALF_NS  = 70
) (
  input  wire logic [3:0]  thresholdCode,
  input  wire logic [15:0] supplyMv,
  output logic             internalOsc,
  output logic             lowSpeedOsc,
  output logic             highSpeedOsc,
  output logic             compLow
);
  // ==========================================================================
  // Oscillators
  // ==========================================================================
  // Free running, half periods above two mclk so the synchroniser sees them
  // One process per pin keeps each oscillator to a single driver
  initial begin
    internalOsc = 1'b0;
    forever #(INT_HALF_NS) internalOsc = ~internalOsc;
  end
  initial begin
    lowSpeedOsc = 1'b0;
    forever #(LOW_HALF_NS) lowSpeedOsc = ~lowSpeedOsc;
  end
  initial begin
    highSpeedOsc = 1'b0;
    forever #(HS_HALF_NS) highSpeedOsc = ~highSpeedOsc;
  end

  // ==========================================================================
  // Comparator
  // ==========================================================================
  // Keeps comparing while detection is off, so the controller's own gating is what counts
  always_comb begin
    compLow = (thresholdCode != 4'h0) && (supplyMv < 16'h06A4 + 16'h0064 * {12'h000, thresholdCode});
  end
endmodule
`default_nettype wire

// file: dv/supply_voltage_detector_ctrl_test.sv
// Self-checking testbench of the supply voltage detector controller
`timescale 1ns/10ps
`default_nettype none
module supply_voltage_detector_ctrl_test;
  import threshold_code_pkg::*;
  localparam int unsigned SIM_INT_DIV = 4;
  localparam int unsigned SIM_HS_DIV  = 8;
  localparam int          INT_HALF    = 60;
  localparam int          LOW_HALF    = 80;
  localparam int          HS_HALF     = 70;

  logic        mclk = 1'b0;
  logic        reset;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        internalOsc;
  logic        lowSpeedOsc;
  logic        highSpeedOsc;
  logic        compLow;
  logic        monitorClk;
  logic        monitorEnable;
  logic [3:0]  thresholdCode;
  logic        dropIrq;
  logic [15:0] supplyMv;
  int          num_errors;
  int          cmp_count;
  int          seed;
  logic [31:0] cc;
  logic [31:0] en;
  logic [31:0] th;
  logic [31:0] mk;
  logic [31:0] rd;
  logic [3:0]  code;

  assign hready = hreadyout;

  threshold_code_ctrl #(.INT_DIV(SIM_INT_DIV), .HS_DIV(SIM_HS_DIV)) dut_u (
    .mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .internalOsc(internalOsc), .lowSpeedOsc(lowSpeedOsc), .highSpeedOsc(highSpeedOsc),
    .compLow(compLow), .monitorClk(monitorClk), .monitorEnable(monitorEnable),
    .thresholdCode(thresholdCode), .dropIrq(dropIrq)
  );

  threshold_code_analog_model #(.INT_HALF_NS(INT_HALF), .LOW_HALF_NS(LOW_HALF), .HS_HALF_NS(HS_HALF)) model_u (
    .thresholdCode(thresholdCode), .supplyMv(supplyMv), .internalOsc(internalOsc),
    .lowSpeedOsc(lowSpeedOsc), .highSpeedOsc(highSpeedOsc), .compLow(compLow)
  );

  // ==========================================================================
  // Clock, watchdog and verdict
  // ==========================================================================
  always #12.5 mclk = ~mclk;

  // Whole sequence needs well under a tenth of this
  initial begin
    #2000000;
    num_errors++;
    print_verdict();
  end

  task automatic print_verdict();
    if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ==========================================================================
  // Shared helpers
  // ==========================================================================
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask

  // Single AHB-Lite transfer, address phase held until hready, then data phase
  task automatic bus_xfer(input logic [15:0] idx, input logic wr, input logic [31:0] data,
                          input logic [2:0] sz, output logic [31:0] rdata);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= {14'h0, idx, 2'h0};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= sz;
    do @(posedge mclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= data;
    do @(posedge mclk); while (hready !== 1'b1);
    rdata = hrdata;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] data);
    logic [31:0] d;
    bus_xfer(idx, 1'b1, data, HSIZE_WORD, d);
  endtask

  task automatic expect_reg(input string name, input logic [15:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    bus_xfer(idx, 1'b0, 32'h00000000, HSIZE_WORD, d);
    check(name, exp, d);
  endtask

  // Re-reads until the value appears or the bound runs out, then compares
  task automatic poll_reg(input string name, input logic [15:0] idx, input logic [31:0] exp);
    int n;
    logic [31:0] d;
    n = 0;
    do begin
      bus_xfer(idx, 1'b0, 32'h00000000, HSIZE_WORD, d);
      n++;
    end while (d !== exp && n < 40);
    check(name, exp, d);
  endtask

  task automatic clk_still(input int n);
    // New setting reaches the pin one edge after the write lands
    @(posedge mclk);
    repeat (n) begin
      @(negedge mclk);
      check("monitor clock idle", 32'h00000000, {31'h0, monitorClk});
    end
  endtask

  // Third and second edges skip the partial first period after a switch
  task automatic clk_period(input realtime exp);
    realtime t0;
    realtime p;
    @(posedge monitorClk);
    @(posedge monitorClk);
    t0 = $realtime;
    @(posedge monitorClk);
    p = $realtime - t0;
    check("monitor clock period ok", 32'h00000001, {31'h0, (p > exp - 30.0) && (p < exp + 30.0)});
  endtask

  function automatic realtime exp_period(input int s);
    if (s == 0) return 2.0 * INT_HALF * SIM_INT_DIV;
    if (s == 1) return 2.0 * LOW_HALF;
    return 2.0 * HS_HALF * SIM_HS_DIV;
  endfunction

  function automatic logic [15:0] level_mv(input logic [3:0] c);
    return 16'h06A4 + 16'h0064 * {12'h000, c};
  endfunction

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    reset = 1'b1;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h00000000;
    supplyMv = 16'h0CE4;
    num_errors = 0;
    cmp_count = 0;
    seed = 32'hECE3;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    // Reset values and bus response
    expect_reg("clock control", IDX_CLOCK_CTRL, 32'h00000004);
    expect_reg("enable", IDX_ENABLE, 32'h00000000);
    expect_reg("threshold", IDX_THRESHOLD, 32'h00000000);
    expect_reg("result", IDX_RESULT, 32'h00000000);
    expect_reg("irq mask", IDX_IRQ_MASK, 32'h00000000);
    expect_reg("drop flag", IDX_DROP_FLAG, 32'h00000000);
    check("hresp", {31'h0, HRESP_OKAY}, {31'h0, hresp});
    check("drop irq", 32'h00000000, {31'h0, dropIrq});
    // Random legal contents, reserved bits written as zero, supply high
    for (int i = 0; i < 8; i++) begin
      cc = $random(seed) & 32'h0000000D;
      en = $random(seed) & 32'h00000001;
      th = $random(seed) & 32'h0000000F;
      mk = $random(seed) & 32'h00000001;
      wr(IDX_CLOCK_CTRL, cc);
      wr(IDX_ENABLE, en);
      wr(IDX_THRESHOLD, th);
      wr(IDX_IRQ_MASK, mk);
      expect_reg("clock control", IDX_CLOCK_CTRL, cc);
      expect_reg("enable", IDX_ENABLE, en);
      expect_reg("threshold", IDX_THRESHOLD, th);
      expect_reg("irq mask", IDX_IRQ_MASK, mk);
      check("monitor enable", en, {31'h0, monitorEnable});
      check("threshold code", th, {28'h0, thresholdCode});
      check("drop irq", 32'h00000000, {31'h0, dropIrq});
    end
    // Byte write ignored, read-only and unmapped places unchanged
    bus_xfer(IDX_THRESHOLD, 1'b1, {28'h0, ~th[3:0]}, 3'h0, rd);
    expect_reg("threshold after byte write", IDX_THRESHOLD, th);
    wr(IDX_RESULT, 32'h00000001);
    expect_reg("result after write", IDX_RESULT, 32'h00000000);
    wr(16'h5105, 32'h00000001);
    expect_reg("unmapped", 16'h5105, 32'h00000000);
    // Every clock source, then reserved source and gate off
    wr(IDX_ENABLE, 32'h00000000);
    for (int s = 0; s < 3; s++) begin
      wr(IDX_CLOCK_CTRL, (s << 2) | 32'h00000001);
      clk_period(exp_period(s));
    end
    wr(IDX_CLOCK_CTRL, 32'h0000000D);
    clk_still(100);
    wr(IDX_CLOCK_CTRL, 32'h00000004);
    clk_still(100);
    // Detection at boundary codes and random ones
    for (int i = 0; i < 5; i++) begin
      code = (i == 0) ? 4'h1 : (i == 1) ? 4'hF : 4'(({$random(seed)} % 15) + 1);
      supplyMv <= level_mv(code);
      wr(IDX_CLOCK_CTRL, 32'h00000005);
      wr(IDX_THRESHOLD, {28'h0, code});
      wr(IDX_IRQ_MASK, 32'h00000000);
      wr(IDX_DROP_FLAG, 32'h00000001);
      wr(IDX_ENABLE, 32'h00000001);
      // Settling time before trusting the result
      repeat (40) @(posedge mclk);
      expect_reg("result at level", IDX_RESULT, 32'h00000000);
      expect_reg("flag at level", IDX_DROP_FLAG, 32'h00000000);
      supplyMv <= level_mv(code) - 16'h0001;
      poll_reg("flag on drop", IDX_DROP_FLAG, 32'h00000001);
      expect_reg("result on drop", IDX_RESULT, 32'h00000001);
      check("drop irq masked", 32'h00000000, {31'h0, dropIrq});
      supplyMv <= 16'h0CE4;
      poll_reg("result recovered", IDX_RESULT, 32'h00000000);
      expect_reg("flag sticky", IDX_DROP_FLAG, 32'h00000001);
      wr(IDX_DROP_FLAG, 32'h00000000);
      expect_reg("flag after zero write", IDX_DROP_FLAG, 32'h00000001);
      wr(IDX_IRQ_MASK, 32'h00000001);
      @(negedge mclk);
      check("drop irq enabled", 32'h00000001, {31'h0, dropIrq});
      wr(IDX_DROP_FLAG, 32'h00000001);
      @(negedge mclk);
      check("drop irq cleared", 32'h00000000, {31'h0, dropIrq});
      expect_reg("flag cleared", IDX_DROP_FLAG, 32'h00000000);
    end
    // Gate off: no detection, registers still reachable
    wr(IDX_CLOCK_CTRL, 32'h00000004);
    supplyMv <= 16'h0600;
    clk_still(60);
    expect_reg("flag while gated", IDX_DROP_FLAG, 32'h00000000);
    expect_reg("enable while gated", IDX_ENABLE, 32'h00000001);
    wr(IDX_CLOCK_CTRL, 32'h00000001);
    poll_reg("flag after ungate", IDX_DROP_FLAG, 32'h00000001);
    @(negedge mclk);
    check("drop irq internal source", 32'h00000001, {31'h0, dropIrq});
    // Detection disabled while the comparator still reports low
    wr(IDX_ENABLE, 32'h00000000);
    wr(IDX_DROP_FLAG, 32'h00000001);
    repeat (60) @(posedge mclk);
    expect_reg("flag while disabled", IDX_DROP_FLAG, 32'h00000000);
    print_verdict();
  end
endmodule
`default_nettype wire
